// ==== bench/rtcca_far_side.sv ====
// free-running oscillator and pulled-up pin outside the core
// assumes the core pulls the pin low through its enable
`timescale 1ns/1ps
`default_nettype none
module rtcca_far_side (
  output var logic osc_clk,
  input wire logic pin_out,
  input wire logic pin_oe,
  output wire logic pin_level
);
  initial begin
    osc_clk = 1'b0;
    forever #24 osc_clk = ~osc_clk;
  end
  // pull-up while released
  assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule // rtcca_far_side
`default_nettype wire

// ==== bench/rtcca_properties.sv ====
// port checker of the calendar/alarm core
// assumes binding onto rtcca_core, all in the sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module rtcca_properties #(
  parameter DIV_W = 15
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic bus_start,
  input wire logic ptr_wrap,
  input wire logic irq_wave_out,
  input wire logic irq_wave_oe
);
  // half-second window, 12 sys_clk per oscillator edge
  localparam int LO = 9 * (1 << (DIV_W - 1)) - 2;
  localparam int HI = 14 * (1 << (DIV_W - 1)) - 2;
  reg [7:0] ctrl_ff;
  wire ctrl_wr = reg_wr && reg_addr == 5'h0E;
  always @(posedge sys_clk) begin
    if (!rst_b) ctrl_ff <= 8'h1C;
    else if (ctrl_wr) ctrl_ff <= reg_wdata;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_time_buffer_hold:
  assert property ((reg_rd && reg_addr == 5'h00 && !bus_start && !ptr_wrap && !$past(bus_start)
    && !$past(ptr_wrap)) ##1 (reg_rd && reg_addr == 5'h00 && !bus_start && !ptr_wrap)
    |=> $stable(reg_rdata)) else $error("seconds buffer moved");
  chk_ctrl_commit:
  assert property (ctrl_wr ##1 (reg_rd && reg_addr == 5'h0E)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("control byte lost");
  chk_alarm_one_store:
  assert property ((reg_wr && reg_addr >= 5'h07 && reg_addr <= 5'h0A)
    ##1 (reg_rd && reg_addr == $past(reg_addr)) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("alarm one byte lost");
  chk_alarm_two_store:
  assert property ((reg_wr && reg_addr >= 5'h0B && reg_addr <= 5'h0D)
    ##1 (reg_rd && reg_addr == $past(reg_addr)) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("alarm two byte lost");
  chk_irq_disabled:
  assert property ($past(ctrl_ff[2:0]) == 3'b100 |-> !irq_wave_oe)
    else $error("pin pulled with enables off");
  chk_pin_level_low:
  assert property (irq_wave_out == 1'b0) else $error("pin drive level high");
  chk_wave_half_sec:
  assert property ((ctrl_ff[4:2] == 3'b000 && reg_wr && reg_addr == 5'h00)
    |-> ##4 irq_wave_oe [*8] ##[LO:HI] !irq_wave_oe) else $error("wave rise misplaced");
  chk_wave_toggles:
  assert property (ctrl_ff[4:2] == 3'b110 && $past(ctrl_ff[4:2]) == 3'b110
    |-> ##[1:40] (irq_wave_oe != $past(irq_wave_oe) || ctrl_wr)) else $error("wave stuck");
endmodule // rtcca_properties
bind rtcca_core rtcca_properties #(.DIV_W(DIV_W)) u_chk (.sys_clk, .rst_b, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_start, .ptr_wrap, .irq_wave_out, .irq_wave_oe);
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench of the calendar/alarm core
// assumes the far-side model supplies oscillator and pin pull-up
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk, rst_b, reg_wr, reg_rd, bus_start, ptr_wrap;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire osc_clk, pin_out, pin_oe, pin_level;
  int err_total, n_checks;
  logic [7:0] set_t [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  logic [7:0] exp_t [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00};
  rtcca_core #(.DIV_W(4)) uut (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .bus_start, .ptr_wrap, .osc_clk, .irq_wave_out(pin_out), .irq_wave_oe(pin_oe));
  rtcca_far_side u_far (.osc_clk, .pin_out, .pin_oe, .pin_level);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // start or pointer wrap, then let the buffer load
  task automatic reload(input logic wrap);
    if (wrap) ptr_wrap <= 1'b1;
    else bus_start <= 1'b1;
    @(posedge sys_clk);
    ptr_wrap <= 1'b0;
    bus_start <= 1'b0;
    idle(2);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #50000;
    err_total++;
    conclude();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, bus_start, ptr_wrap} = 5'h00;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    rd(5'h0E, 8'h1C);
    rd(5'h0F, 8'hC8);
    for (int i = 7; i < 14; i++) begin
      wr(i[4:0], 8'h80 | i[7:0]);
      rd(i[4:0], 8'h80 | i[7:0]);
    end
    $display("end storage test");
    wr(5'h0E, 8'h00);
    wr(5'h00, 8'h00);
    idle(140);
    wr(5'h0E, 8'h18);
    idle(60);
    wr(5'h0E, 8'h1C);
    $display("end wave test");
    for (int j = 0; j < 7; j++) wr(j[4:0], set_t[j]);
    idle(260);
    reload(1'b0);
    for (int j = 0; j < 8; j++) rd((j == 0) ? 5'h00 : 5'(j - 1), exp_t[j]);
    wr(5'h00, 8'h59);
    wr(5'h01, 8'h59);
    wr(5'h02, 8'h51);
    idle(260);
    reload(1'b1);
    rd(5'h02, 8'h72);
    $display("end calendar test");
    wr(5'h07, 8'h00);
    wr(5'h0F, 8'hC8);
    wr(5'h0E, 8'h07);
    rd(5'h0E, 8'h07);
    wr(5'h00, 8'h59);
    idle(260);
    rd(5'h0F, 8'hCB);
    chk("pin", 8'h00, {7'h00, pin_level});
    wr(5'h0F, 8'hCB);
    rd(5'h0F, 8'hCB);
    wr(5'h0F, 8'hCA);
    rd(5'h0F, 8'hCA);
    wr(5'h0E, 8'h05);
    idle(2);
    chk("pin", 8'h01, {7'h00, pin_level});
    wr(5'h00, 8'h59);
    wr(5'h01, 8'h10);
    wr(5'h02, 8'h08);
    wr(5'h03, 8'h03);
    wr(5'h04, 8'h15);
    wr(5'h07, 8'h30);
    wr(5'h0B, 8'h11);
    wr(5'h0C, 8'h08);
    wr(5'h0D, 8'h43);
    wr(5'h0F, 8'hC8);
    idle(260);
    rd(5'h0F, 8'hCA);
    $display("end alarm test");
    conclude();
  end
endmodule // tb
`default_nettype wire

// ==== verilog/rtcca_core.v ====
// BCD time/date counters, read buffers, two alarms and the shared irq/wave pin
// assumes a serial front end on sys_clk giving strobes, start and pointer-wrap pulses
// Notes on behaviour
// - hour bit 6 high selects 12-hour counting
// - 12-hour: hour bit 5 set means afternoon
// - 24-hour: hour bit 5 is twenty tens
// - century bit toggles when year wraps 99->00
// - weekday advances at midnight, host numbers sequentially
// - host time reads use buffers (alarm, control, status read direct), host writes go straight to the counters, counters keep running
// - read buffers reload on start and pointer wrap
// - seconds write resets sub-second divider
// - written byte commits at its acknowledge strobe
// - 1Hz wave rises 500ms after seconds write
// - alarm one lives at 07h..0Ah
// - alarm two lives at 0Bh..0Dh, no seconds
// - bit 7 of alarm bytes masks field
// - day/date bit 6 picks weekday or monthday
// - match sets alarm flag regardless of enables
// - pin low on flag only if enabled, irq mode
// - alarms compared at once-per-second counter update
// - alarm one masks: second..date match levels
// - alarm two all masked: each minute at :00
// - flags clear on written zero, one ignored
// - wave mode drives square wave, flags still set
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rtcca_defs.vh"

module rtcca_core #(
  parameter DIV_W = `RTCCA_OSC_DIV_W
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire bus_start,
  input wire ptr_wrap,
  input wire osc_clk,
  output wire irq_wave_out,
  output reg irq_wave_oe
);

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  function field_hit;
    input [7:0] al;
    input [6:0] cur;
    begin
      field_hit = al[`RTCCA_MASK_BIT] | (al[6:0] == cur);
    end
  endfunction

  function [2:0] alarm_slot;
    input [4:0] a;
    reg [4:0] off;
    begin
      off = a - `RTCCA_A_AL1_FIRST;
      alarm_slot = off[2:0];
    end
  endfunction

  function [5:0] month_len;
    input [4:0] mon;
    input [7:0] yr;
    reg leap;
    begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
        5'h02: month_len = leap ? 6'h29 : 6'h28;
        5'h04, 5'h06, 5'h09, 5'h11: month_len = 6'h30;
        default: month_len = 6'h31;
      endcase
    end
  endfunction

  // oscillator edge detection
  reg osc_meta_ff;
  reg osc_sync_ff;
  reg osc_prev_ff;
  reg [DIV_W-1:0] div_ff;
  wire osc_edge;
  wire tick;

  reg [7:0] sec_ff;
  reg [7:0] min_ff;
  reg [7:0] hour_ff;
  reg [7:0] wday_ff;
  reg [7:0] mday_ff;
  reg [7:0] month_ff;
  reg [7:0] year_ff;
  reg [7:0] alarm_ff [0:6];
  reg [7:0] rbuf_ff [0:6];
  reg [7:0] ctrl_ff;
  reg [7:0] stat_ff;
  reg wave_tap;

  reg [7:0] nxt_sec;
  reg [7:0] nxt_min;
  reg [7:0] nxt_hour;
  reg [7:0] nxt_wday;
  reg [7:0] nxt_mday;
  reg [7:0] nxt_month;
  reg [7:0] nxt_year;
  reg midnight;
  reg [4:0] h12;
  reg [7:0] h12_inc;
  reg [7:0] hour_inc;
  reg [7:0] month_inc;

  wire wr_sec = reg_wr && (reg_addr == `RTCCA_A_SEC);
  wire wr_min = reg_wr && (reg_addr == `RTCCA_A_MIN);
  wire wr_hour = reg_wr && (reg_addr == `RTCCA_A_HOUR);
  wire wr_wday = reg_wr && (reg_addr == `RTCCA_A_WDAY);
  wire wr_mday = reg_wr && (reg_addr == `RTCCA_A_MDAY);
  wire wr_month = reg_wr && (reg_addr == `RTCCA_A_MONTH);
  wire wr_year = reg_wr && (reg_addr == `RTCCA_A_YEAR);
  wire wr_alarm = reg_wr && (reg_addr >= `RTCCA_A_AL1_FIRST) && (reg_addr <= `RTCCA_A_AL2_LAST);
  wire wr_ctrl = reg_wr && (reg_addr == `RTCCA_A_CTRL);
  wire wr_stat = reg_wr && (reg_addr == `RTCCA_A_STAT);
  wire clr1 = wr_stat && !reg_wdata[`RTCCA_STAT_F1];
  wire clr2 = wr_stat && !reg_wdata[`RTCCA_STAT_F2];
  integer i;
  integer k;

  // faster wave taps fall back inside a short divider
  localparam TAP_1K = (DIV_W > 5) ? 4 : DIV_W - 2;
  localparam TAP_4K = (DIV_W > 3) ? 2 : DIV_W - 2;

  assign osc_edge = osc_sync_ff & ~osc_prev_ff;
  assign tick = osc_edge && (&div_ff);
  assign irq_wave_out = 1'b0;

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
      div_ff <= {DIV_W{1'b0}};
    end else begin
      osc_meta_ff <= osc_clk;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
      if (wr_sec) begin
        div_ff <= {DIV_W{1'b0}};
      end else if (osc_edge) begin
        div_ff <= div_ff + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // next time and date, taken only on tick
  always @* begin
    nxt_sec = bcd_inc(sec_ff);
    nxt_min = min_ff;
    nxt_hour = hour_ff;
    nxt_wday = wday_ff;
    nxt_mday = mday_ff;
    nxt_month = month_ff;
    nxt_year = year_ff;
    midnight = 1'b0;
    h12 = hour_ff[4:0];
    h12_inc = bcd_inc({3'b000, hour_ff[4:0]});
    hour_inc = bcd_inc({2'b00, hour_ff[5:0]});
    month_inc = bcd_inc({3'b000, month_ff[4:0]});
    if (sec_ff == 8'h59) begin
      nxt_sec = 8'h00;
      nxt_min = bcd_inc(min_ff);
      if (min_ff == 8'h59) begin
        nxt_min = 8'h00;
        if (hour_ff[`RTCCA_H12_BIT]) begin
          if (h12 == 5'h12) begin
            nxt_hour = {hour_ff[7:5], 5'h01};
          end else if (h12 == 5'h11) begin
            nxt_hour = {hour_ff[7:6], ~hour_ff[`RTCCA_PM_BIT], 5'h12};
            midnight = hour_ff[`RTCCA_PM_BIT];
          end else begin
            nxt_hour = {hour_ff[7:5], h12_inc[4:0]};
          end
        end else if (hour_ff[5:0] == 6'h23) begin
          nxt_hour = {hour_ff[7:6], 6'h00};
          midnight = 1'b1;
        end else begin
          nxt_hour = {hour_ff[7:6], hour_inc[5:0]};
        end
      end
    end
    if (midnight) begin
      nxt_wday = (wday_ff[2:0] == 3'h7) ? 8'h01 : {5'h00, wday_ff[2:0] + 3'h1};
      nxt_mday = bcd_inc(mday_ff);
      if (mday_ff[5:0] == month_len(month_ff[4:0], year_ff)) begin
        nxt_mday = 8'h01;
        nxt_month = {month_ff[7:5], month_inc[4:0]};
        if (month_ff[4:0] == 5'h12) begin
          nxt_month = {month_ff[7:5], 5'h01};
          nxt_year = bcd_inc(year_ff);
          if (year_ff == 8'h99) begin
            nxt_year = 8'h00;
            nxt_month[`RTCCA_CENT_BIT] = ~month_ff[`RTCCA_CENT_BIT];
          end
        end
      end
    end
  end

  // alarm evaluation against the values the counters take on this tick
  wire [5:0] al1_dd = alarm_ff[3][`RTCCA_SEL_BIT] ? nxt_wday[5:0] : nxt_mday[5:0];
  wire [5:0] al2_dd = alarm_ff[6][`RTCCA_SEL_BIT] ? nxt_wday[5:0] : nxt_mday[5:0];
  wire al1_match = field_hit(alarm_ff[0], nxt_sec[6:0])
                 & field_hit(alarm_ff[1], nxt_min[6:0])
                 & field_hit(alarm_ff[2], nxt_hour[6:0])
                 & field_hit({alarm_ff[3][7], 1'b0, alarm_ff[3][5:0]}, {1'b0, al1_dd});
  wire al2_match = (nxt_sec == 8'h00)
                 & field_hit(alarm_ff[4], nxt_min[6:0])
                 & field_hit(alarm_ff[5], nxt_hour[6:0])
                 & field_hit({alarm_ff[6][7], 1'b0, alarm_ff[6][5:0]}, {1'b0, al2_dd});
  wire set1 = tick & al1_match;
  wire set2 = tick & al2_match;

  // writes commit on the strobe, which is the acknowledge of the byte
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      sec_ff <= `RTCCA_SEC_RST;
      min_ff <= `RTCCA_MIN_RST;
      hour_ff <= `RTCCA_HOUR_RST;
      wday_ff <= `RTCCA_WDAY_RST;
      mday_ff <= `RTCCA_MDAY_RST;
      month_ff <= `RTCCA_MONTH_RST;
      year_ff <= `RTCCA_YEAR_RST;
    end else begin
      if (wr_sec) begin
        sec_ff <= {1'b0, reg_wdata[6:0]};
      end else if (tick) begin
        sec_ff <= nxt_sec;
      end
      if (wr_min) begin
        min_ff <= {1'b0, reg_wdata[6:0]};
      end else if (tick) begin
        min_ff <= nxt_min;
      end
      if (wr_hour) begin
        hour_ff <= {1'b0, reg_wdata[6:0]};
      end else if (tick) begin
        hour_ff <= nxt_hour;
      end
      if (wr_wday) begin
        wday_ff <= {5'h00, reg_wdata[2:0]};
      end else if (tick) begin
        wday_ff <= nxt_wday;
      end
      if (wr_mday) begin
        mday_ff <= {2'b00, reg_wdata[5:0]};
      end else if (tick) begin
        mday_ff <= nxt_mday;
      end
      if (wr_month) begin
        month_ff <= {reg_wdata[7], 2'b00, reg_wdata[4:0]};
      end else if (tick) begin
        month_ff <= nxt_month;
      end
      if (wr_year) begin
        year_ff <= reg_wdata;
      end else if (tick) begin
        year_ff <= nxt_year;
      end
    end
  end

  // alarm and control bytes are plain storage
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_ff <= `RTCCA_CTRL_RST;
      for (i = 0; i < 7; i = i + 1) begin
        alarm_ff[i] <= 8'h00;
      end
    end else begin
      if (wr_alarm) begin
        alarm_ff[alarm_slot(reg_addr)] <= reg_wdata;
      end
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata;
      end
    end
  end

  // flags: set wins over a written zero, a written one leaves the flag
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      stat_ff <= `RTCCA_STAT_RST;
    end else begin
      if (wr_stat) begin
        stat_ff[7:3] <= reg_wdata[7:3];
      end
      stat_ff[`RTCCA_STAT_BUSY] <= 1'b0;
      stat_ff[`RTCCA_STAT_F1] <= set1 | (stat_ff[`RTCCA_STAT_F1] & ~clr1);
      stat_ff[`RTCCA_STAT_F2] <= set2 | (stat_ff[`RTCCA_STAT_F2] & ~clr2);
    end
  end

  // read buffers hold a snapshot while counting continues
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      for (k = 0; k < 7; k = k + 1) begin
        rbuf_ff[k] <= 8'h00;
      end
    end else if (bus_start || ptr_wrap) begin
      rbuf_ff[0] <= sec_ff;
      rbuf_ff[1] <= min_ff;
      rbuf_ff[2] <= hour_ff;
      rbuf_ff[3] <= wday_ff;
      rbuf_ff[4] <= mday_ff;
      rbuf_ff[5] <= month_ff;
      rbuf_ff[6] <= year_ff;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr <= `RTCCA_A_YEAR) begin
        reg_rdata <= rbuf_ff[reg_addr[2:0]];
      end else if (reg_addr <= `RTCCA_A_AL2_LAST) begin
        reg_rdata <= alarm_ff[alarm_slot(reg_addr)];
      end else if (reg_addr == `RTCCA_A_CTRL) begin
        reg_rdata <= ctrl_ff;
      end else if (reg_addr == `RTCCA_A_STAT) begin
        reg_rdata <= stat_ff;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // square wave taps; 1Hz tap rises at half count after a seconds write
  always @* begin
    case (ctrl_ff[`RTCCA_CTRL_RS_HI:`RTCCA_CTRL_RS_LO])
      2'b00: wave_tap = div_ff[DIV_W-1];
      2'b01: wave_tap = div_ff[TAP_1K];
      2'b10: wave_tap = div_ff[TAP_4K];
      default: wave_tap = div_ff[1];
    endcase
  end

  // open-drain, active low: enable high pulls the pin low
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_wave_oe <= 1'b0;
    end else if (ctrl_ff[`RTCCA_CTRL_INTSEL]) begin
      irq_wave_oe <= (stat_ff[`RTCCA_STAT_F1] & ctrl_ff[`RTCCA_CTRL_IE1])
                   | (stat_ff[`RTCCA_STAT_F2] & ctrl_ff[`RTCCA_CTRL_IE2]);
    end else begin
      irq_wave_oe <= ~wave_tap;
    end
  end

endmodule // rtcca_core
`default_nettype wire

// ==== verilog/rtcca_defs.vh ====
// register map, field positions and reset values of the calendar/alarm core
// assumes inclusion by the core file only
`ifndef RTCCA_DEFS_VH
`define RTCCA_DEFS_VH
`define RTCCA_A_SEC 5'h00
`define RTCCA_A_MIN 5'h01
`define RTCCA_A_HOUR 5'h02
`define RTCCA_A_WDAY 5'h03
`define RTCCA_A_MDAY 5'h04
`define RTCCA_A_MONTH 5'h05
`define RTCCA_A_YEAR 5'h06
`define RTCCA_A_AL1_FIRST 5'h07
`define RTCCA_A_AL1_LAST 5'h0A
`define RTCCA_A_AL2_FIRST 5'h0B
`define RTCCA_A_AL2_LAST 5'h0D
`define RTCCA_A_CTRL 5'h0E
`define RTCCA_A_STAT 5'h0F
`define RTCCA_MASK_BIT 7
`define RTCCA_SEL_BIT 6
`define RTCCA_H12_BIT 6
`define RTCCA_PM_BIT 5
`define RTCCA_CENT_BIT 7
`define RTCCA_CTRL_INTSEL 2
`define RTCCA_CTRL_IE2 1
`define RTCCA_CTRL_IE1 0
`define RTCCA_CTRL_RS_HI 4
`define RTCCA_CTRL_RS_LO 3
`define RTCCA_STAT_F2 1
`define RTCCA_STAT_F1 0
`define RTCCA_STAT_BUSY 2
`define RTCCA_CTRL_RST 8'h1C
`define RTCCA_STAT_RST 8'hC8
`define RTCCA_SEC_RST 8'h00
`define RTCCA_MIN_RST 8'h00
`define RTCCA_HOUR_RST 8'h00
`define RTCCA_WDAY_RST 8'h01
`define RTCCA_MDAY_RST 8'h01
`define RTCCA_MONTH_RST 8'h01
`define RTCCA_YEAR_RST 8'h00
`define RTCCA_OSC_DIV_W 15
`endif
